// [boost_gate_map.vh]
// register offsets, fields, resets and timing for the boost gate drive control block
`ifndef BOOST_GATE_MAP_VH
`define BOOST_GATE_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00c
`define REG_TIMING 12'h010
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_ENABLE 0
`define CTRL_DIODE_EMU 1
`define CTRL_RESET 32'h00000000
// ----------------------------------------
// irq bits
// ----------------------------------------
`define IRQ_PEAK 0
`define IRQ_BYPASS 1
`define IRQ_HICCUP 2
`define IRQ_THERMAL 3
`define IRQ_WIDTH 4
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define REPLENISH_NS 75
`define REPLENISH_CYC ((`REPLENISH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_REPLENISH 4
`define MAX_SETS 4
`define SKIP_CYCLES 12
`define HICCUP_CYCLES 512
`define TIMING_RESET 32'h00000302
`endif

// [boost_gate_drive_control.v]
// gate command sequencing for a synchronous boost controller with ahb-lite registers
// Behaviour
// R1: end low-side on-phase when pwm comparator trips
// R2: peak limit trip ends low-side immediately
// R3: skip pulses while current stays above limit
// R4: enforce minimum off-time every cycle
// R5: omit pulse shorter than minimum on-time
// R6: overvoltage with supply above target holds high-side
// R7: low-side driver needs enable and drive supply
// R8: high-side driver needs enable and boot supply
// R9: gate commands never both asserted
// R10: low-side on waits high-side off plus delay
// R11: high-side on waits low-side off plus delay
// R12: boot lockout forces low-side on for 75 ns
// R13: four replenish pulses then skip 12 cycles
// R14: four failed sets give 512-cycle hiccup
// R15: hiccup grounds power-good and soft-start
// R16: over-temperature disables drivers and regulator
// R17: diode emulation zero current ends high-side
// R18: hiccup end releases pulldowns, fresh soft-start
// R19: boot recovery clears replenish and set counters
`timescale 1ns/1ps
`include "boost_gate_map.vh"
module boost_gate_drive_control #(
  parameter HICCUP_CYCLES = `HICCUP_CYCLES
) (
  input wire mclk,
  input wire resetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire cycleStart,
  input wire pwmTrip,
  input wire peakLimitTrip,
  input wire zeroCurrentTrip,
  input wire overvoltageTrip,
  input wire supplyAboveTarget,
  input wire driveSupplyOk,
  input wire bootSupplyOk,
  input wire overTempShutdown,
  input wire lowGateSensed,
  input wire highGateSensed,
  input wire enablePin,
  output reg low_gate_cmd,
  output reg high_gate_cmd,
  output reg outputOkPullOe,
  output reg softStartPullOe,
  output reg driveRegEnable,
  output reg irq
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam NS = 12;
  reg [NS-1:0] syncA_q;
  reg [NS-1:0] syncB_q;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      syncA_q <= {NS{1'b0}};
      syncB_q <= {NS{1'b0}};
    end else begin
      syncA_q <= {cycleStart, pwmTrip, peakLimitTrip, zeroCurrentTrip, overvoltageTrip,
        supplyAboveTarget, driveSupplyOk, bootSupplyOk, overTempShutdown,
        lowGateSensed, highGateSensed, enablePin};
      syncB_q <= syncA_q;
    end
  end
  wire cycStartS = syncB_q[11];
  wire pwmS = syncB_q[10];
  wire peakS = syncB_q[9];
  wire zcdS = syncB_q[8];
  wire ovS = syncB_q[7];
  wire supS = syncB_q[6];
  wire vccOkS = syncB_q[5];
  wire bootOkS = syncB_q[4];
  wire tsdS = syncB_q[3];
  wire loSenseS = syncB_q[2];
  wire hoSenseS = syncB_q[1];
  wire enPinS = syncB_q[0];
  reg cycPrev_q;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cycPrev_q <= 1'b0;
    end else begin
      cycPrev_q <= cycStartS;
    end
  end
  // reset value equals the idle pin level, so no false cycle start after reset
  wire cycTick = cycStartS & ~cycPrev_q;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [31:0] ctrl_q;
  reg [31:0] timing_q;
  reg [`IRQ_WIDTH-1:0] irqStat_q;
  reg [`IRQ_WIDTH-1:0] irqMask_q;
  reg dpWrite_q;
  reg dpRead_q;
  reg [11:0] dpAddr_q;
  wire enable = ctrl_q[`CTRL_ENABLE] & enPinS;
  wire diodeEmu = ctrl_q[`CTRL_DIODE_EMU];
  wire [3:0] minOnCyc = timing_q[3:0];
  wire [3:0] minOffCyc = timing_q[11:8];
  wire [`IRQ_WIDTH-1:0] irqEvent;
  wire addrPhase = hsel & hready & htrans[1];
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dpWrite_q <= 1'b0;
      dpRead_q <= 1'b0;
      dpAddr_q <= 12'h000;
    end else begin
      dpWrite_q <= addrPhase & hwrite;
      dpRead_q <= addrPhase & ~hwrite;
      if (addrPhase) begin
        dpAddr_q <= haddr;
      end
    end
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `CTRL_RESET;
      timing_q <= `TIMING_RESET;
      irqMask_q <= {`IRQ_WIDTH{1'b0}};
      irqStat_q <= {`IRQ_WIDTH{1'b0}};
    end else begin
      // hwdata is valid only in the data phase, one cycle after the address
      if (dpWrite_q && dpAddr_q == `REG_CTRL) begin
        ctrl_q <= hwdata & 32'h00000003;
      end
      if (dpWrite_q && dpAddr_q == `REG_TIMING) begin
        timing_q <= hwdata & 32'h00000f0f;
      end
      if (dpWrite_q && dpAddr_q == `REG_IRQ_MASK) begin
        irqMask_q <= hwdata[`IRQ_WIDTH-1:0];
      end
      // a new event in the clear cycle survives
      if (dpWrite_q && dpAddr_q == `REG_IRQ_STAT)
        irqStat_q <= (irqStat_q & ~hwdata[`IRQ_WIDTH-1:0]) | irqEvent;
      else
        irqStat_q <= irqStat_q | irqEvent;
    end
  end
  // ----------------------------------------
  // switching sequencer
  // ----------------------------------------
  localparam S_OFF = 6'h01;
  localparam S_DLH = 6'h02;
  localparam S_LOW = 6'h04;
  localparam S_DHL = 6'h08;
  localparam S_HIGH = 6'h10;
  localparam S_HICCUP = 6'h20;
  localparam [9:0] SKIP_WAIT = `SKIP_CYCLES;
  reg [5:0] state_q;
  reg [3:0] phaseCnt_q;
  reg [9:0] waitCnt_q;
  reg [2:0] repCnt_q;
  reg [2:0] setCnt_q;
  reg replenish_q;
  reg bypass_q;
  reg peakHeld_q;
  reg hiDone_q;
  reg lowReq_q;
  // lockouts act on synced levels, two cycles behind the pins
  wire lowDrvOk = enable & vccOkS & ~tsdS; // R7 R16
  wire highDrvOk = enable & bootOkS & ~tsdS; // R8 R16
  wire bypassReq = supS & ovS; // R6
  wire lowAllowed = lowDrvOk & ~peakS & ~peakHeld_q; // R2 R3
  // five bits so that a large min-off setting cannot wrap the sum
  wire [4:0] lowSpan = {1'b0, phaseCnt_q} + 5'h01 + {1'b0, minOffCyc};
  // comparator already tripped before the on-phase: the pulse would be too short
  wire shortPulse = pwmS && (minOnCyc > 4'h0) && state_q == S_DHL && !replenish_q; // R5
  assign irqEvent = {tsdS, (state_q == S_HICCUP), bypassReq & ~bypass_q, peakS};
  function [3:0] inc4;
    input [3:0] v;
    inc4 = (v == 4'hf) ? v : v + 4'h1;
  endfunction
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_OFF;
      phaseCnt_q <= 4'h0;
      waitCnt_q <= 10'h000;
      repCnt_q <= 3'h0;
      setCnt_q <= 3'h0;
      replenish_q <= 1'b0;
      bypass_q <= 1'b0;
      peakHeld_q <= 1'b0;
      hiDone_q <= 1'b0;
      lowReq_q <= 1'b0;
    end else begin
      phaseCnt_q <= inc4(phaseCnt_q);
      if (cycTick) peakHeld_q <= peakS; // R3
      if (cycTick) bypass_q <= bypassReq; // R6
      if (cycTick) hiDone_q <= 1'b0;
      if (bootOkS && state_q != S_HICCUP) begin
        repCnt_q <= 3'h0; // R19
        setCnt_q <= 3'h0; // R19
      end
      if (cycTick && waitCnt_q != 10'h000 && state_q != S_HICCUP) begin
        waitCnt_q <= waitCnt_q - 10'h001; // R13
      end
      case (state_q)
        S_OFF: begin
          if (cycTick && waitCnt_q == 10'h000 && lowAllowed && !bypassReq) begin
            lowReq_q <= 1'b1;
            replenish_q <= ~bootOkS; // R12
            state_q <= S_DHL;
            phaseCnt_q <= 4'h0;
          end else if (highDrvOk && !hiDone_q && !lowReq_q && !(diodeEmu && zcdS)) begin
            state_q <= S_DLH;
            phaseCnt_q <= 4'h0;
          end
        end
        S_DHL: begin
          if (shortPulse) begin
            state_q <= S_OFF; // R5
            lowReq_q <= 1'b0;
          end else if (!hoSenseS && phaseCnt_q >= 4'h1) begin // R10
            state_q <= S_LOW;
            phaseCnt_q <= 4'h0;
          end
        end
        S_LOW: begin
          lowReq_q <= 1'b0;
          // a replenish pulse ignores the pwm comparator; only time or lockout ends it
          if (replenish_q) begin
            if (phaseCnt_q >= `REPLENISH_CYC - 1 || !lowDrvOk) begin // R12
              state_q <= S_OFF;
              replenish_q <= 1'b0;
              if (repCnt_q == `MAX_REPLENISH - 1) begin // R13
                repCnt_q <= 3'h0;
                if (setCnt_q == `MAX_SETS - 1) begin // R14
                  setCnt_q <= 3'h0;
                  state_q <= S_HICCUP;
                  waitCnt_q <= HICCUP_CYCLES[9:0] - 10'h001;
                end else begin
                  setCnt_q <= setCnt_q + 3'h1;
                  waitCnt_q <= SKIP_WAIT; // R13
                end
              end else begin
                repCnt_q <= repCnt_q + 3'h1;
              end
            end
          // R1 R2 R4: pwm trip ends on-phase, but not before minimum on-time; peak trip ends it at once
          end else if (peakS || !lowDrvOk || cycTick || lowSpan >= 5'h0f ||
              (pwmS && phaseCnt_q + 4'h1 >= minOnCyc)) begin // R4 R5
            state_q <= S_OFF;
          end
        end
        S_DLH: begin
          // R11
          if (!loSenseS && phaseCnt_q >= 4'h1) begin
            state_q <= S_HIGH;
            phaseCnt_q <= 4'h0;
          end
        end
        S_HIGH: begin
          if (!highDrvOk || (diodeEmu && zcdS && !bypass_q)) begin // R17
            state_q <= S_OFF;
            hiDone_q <= 1'b1;
          end else if (cycTick && lowAllowed && !bypassReq) begin
            lowReq_q <= 1'b1;
            replenish_q <= ~bootOkS;
            state_q <= S_DHL; // R10
            phaseCnt_q <= 4'h0;
          end
        end
        S_HICCUP: begin
          // the off-time counts switching cycles, not mclk periods
          if (cycTick) begin
            if (waitCnt_q == 10'h000) begin
              state_q <= S_OFF; // R18
            end else begin
              waitCnt_q <= waitCnt_q - 10'h001;
            end
          end
        end
        default: state_q <= S_OFF;
      endcase
    end
  end
  // ----------------------------------------
  // gate, pulldown, regulator and irq outputs
  // ----------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      low_gate_cmd <= 1'b0;
      high_gate_cmd <= 1'b0;
      outputOkPullOe <= 1'b1;
      softStartPullOe <= 1'b1;
      driveRegEnable <= 1'b0;
      irq <= 1'b0;
    end else begin
      low_gate_cmd <= (state_q == S_LOW) && lowDrvOk && !shortPulse; // R9
      high_gate_cmd <= (state_q == S_HIGH) && highDrvOk; // R9
      outputOkPullOe <= (state_q == S_HICCUP) || !enable || tsdS || !vccOkS; // R15
      softStartPullOe <= (state_q == S_HICCUP) || !enable; // R15 R18
      driveRegEnable <= enable & ~tsdS; // R16
      irq <= |(irqStat_q & irqMask_q);
    end
  end
  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  // zero wait states: read data is fetched at the address edge and stands one cycle
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      if (addrPhase && !hwrite) begin
        case (haddr)
          `REG_CTRL: hrdata <= ctrl_q;
          `REG_STATUS: hrdata <= {18'h00000, setCnt_q[1:0], repCnt_q[1:0], bypass_q,
            state_q, high_gate_cmd, low_gate_cmd, tsdS};
          `REG_IRQ_STAT: hrdata <= {28'h0000000, irqStat_q};
          `REG_IRQ_MASK: hrdata <= {28'h0000000, irqMask_q};
          `REG_TIMING: hrdata <= timing_q;
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // boost_gate_drive_control

// [boost_gate_checker.sv]
// assertions on the gate and pulldown outputs
`timescale 1ns/1ps
module boost_gate_checker #(
  parameter HICCUP_CYCLES = 512
) (
  input wire mclk,
  input wire resetn,
  input wire peakLimitTrip,
  input wire driveSupplyOk,
  input wire bootSupplyOk,
  input wire overTempShutdown,
  input wire lowGateSensed,
  input wire highGateSensed,
  input wire enablePin,
  input wire low_gate_cmd,
  input wire high_gate_cmd,
  input wire outputOkPullOe,
  input wire softStartPullOe,
  input wire driveRegEnable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // ----
  // gate checks
  // ----
  a_gates_exclusive: assert property (!(low_gate_cmd && high_gate_cmd))
    else $error("both gates on");
  a_low_dead_time: assert property ($rose(low_gate_cmd) |-> !$past(highGateSensed, 2))
    else $error("low on while high gate up");
  a_high_dead_time: assert property ($rose(high_gate_cmd) |-> !$past(lowGateSensed, 2))
    else $error("high on while low gate up");
  // inputs pass two flops, so four low samples must have reached the gates
  a_low_supply: assert property ((!driveSupplyOk || !enablePin)[*4] |-> !low_gate_cmd)
    else $error("low on without supply");
  a_high_boot: assert property ((!bootSupplyOk || !enablePin)[*4] |-> !high_gate_cmd)
    else $error("high on without boot");
  a_thermal_off: assert property (overTempShutdown[*4] |->
    !low_gate_cmd && !high_gate_cmd && !driveRegEnable) else $error("hot but driving");
  a_peak_cut: assert property ((peakLimitTrip && bootSupplyOk)[*5] |-> !low_gate_cmd)
    else $error("low on above peak limit");
  a_min_off: assert property ($fell(low_gate_cmd) |-> !low_gate_cmd[*3])
    else $error("off time too short");
  a_hiccup_quiet: assert property (softStartPullOe |->
    !low_gate_cmd && !high_gate_cmd && outputOkPullOe) else $error("switching in hiccup");
  c_hiccup: cover property ($rose(softStartPullOe));
  c_low_pulse: cover property ($fell(low_gate_cmd));
  c_high_on: cover property ($rose(high_gate_cmd));
endmodule // boost_gate_checker

bind boost_gate_drive_control boost_gate_checker #(.HICCUP_CYCLES(HICCUP_CYCLES)) chk_i (
  .mclk(mclk), .resetn(resetn), .peakLimitTrip(peakLimitTrip), .driveSupplyOk(driveSupplyOk),
  .bootSupplyOk(bootSupplyOk), .overTempShutdown(overTempShutdown), .enablePin(enablePin),
  .lowGateSensed(lowGateSensed), .highGateSensed(highGateSensed),
  .low_gate_cmd(low_gate_cmd), .high_gate_cmd(high_gate_cmd), .outputOkPullOe(outputOkPullOe),
  .softStartPullOe(softStartPullOe), .driveRegEnable(driveRegEnable)
);

// [power_switch_model.sv]
// behavioural pair of external power switches
`timescale 1ns/1ps
module power_switch_model (
  input wire mclk,
  input wire slowGate,
  input wire lowCmd,
  input wire highCmd,
  output reg lowSensed = 1'b0,
  output reg highSensed = 1'b0
);
  reg [2:0] lowBleed_q = 3'h0;
  reg [2:0] highBleed_q = 3'h0;
  // gate charge lingers after the command drops; a slow gate stretches the dead-time
  always @(posedge mclk) begin
    lowBleed_q <= lowCmd ? (slowGate ? 3'h5 : 3'h1) : lowBleed_q - {2'h0, lowBleed_q != 3'h0};
    highBleed_q <= highCmd ? (slowGate ? 3'h5 : 3'h1) : highBleed_q - {2'h0, highBleed_q != 3'h0};
    lowSensed <= lowCmd || lowBleed_q != 3'h0;
    highSensed <= highCmd || highBleed_q != 3'h0;
  end
endmodule // power_switch_model

// [boost_gate_drive_control_tb_top.sv]
// self-checking bench for the boost gate drive control block
`timescale 1ns/1ps
`include "boost_gate_map.vh"
module boost_gate_drive_control_tb_top;
  reg mclk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cycleStart = 1'b0, slowGate = 1'b0;
  reg pwmTrip = 1'b0, peakLimitTrip = 1'b0, zeroCurrentTrip = 1'b0, overvoltageTrip = 1'b0;
  reg supplyAboveTarget = 1'b0, overTempShutdown = 1'b0, enablePin = 1'b1;
  reg driveSupplyOk = 1'b1, bootSupplyOk = 1'b1;
  reg [11:0] haddr = 12'h000;
  reg [1:0] htrans = 2'h0;
  reg [31:0] hwdata = 32'h00000000;
  reg [31:0] rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, lowCmd, highCmd, okPull, ssPull, regEn, irq, lowSensed, highSensed;
  integer num_errors = 0, checks = 0, cyc = 0, onCnt = 0, base, i, n;
  boost_gate_drive_control #(.HICCUP_CYCLES(8)) boost_gate_drive_control_i (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cycleStart(cycleStart), .pwmTrip(pwmTrip), .peakLimitTrip(peakLimitTrip),
    .zeroCurrentTrip(zeroCurrentTrip), .overvoltageTrip(overvoltageTrip),
    .supplyAboveTarget(supplyAboveTarget), .driveSupplyOk(driveSupplyOk),
    .bootSupplyOk(bootSupplyOk), .overTempShutdown(overTempShutdown),
    .lowGateSensed(lowSensed), .highGateSensed(highSensed), .enablePin(enablePin),
    .low_gate_cmd(lowCmd), .high_gate_cmd(highCmd), .outputOkPullOe(okPull),
    .softStartPullOe(ssPull), .driveRegEnable(regEn), .irq(irq)
  );
  power_switch_model power_switch_model_i (.mclk(mclk), .slowGate(slowGate), .lowCmd(lowCmd),
    .highCmd(highCmd), .lowSensed(lowSensed), .highSensed(highSensed));
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    onCnt <= onCnt + (lowCmd === 1'b1);
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd = hrdata;
    end
  endtask
  task tick(input integer len);
    begin
      cycleStart <= 1'b1;
      repeat (3) @(posedge mclk);
      cycleStart <= 1'b0;
      repeat (len) @(posedge mclk);
    end
  endtask
  task testRegs;
    begin
      bus(1'b0, `REG_CTRL, 0);
      chk("ctrl", `CTRL_RESET, rd);
      bus(1'b0, `REG_TIMING, 0);
      chk("timing", `TIMING_RESET, rd);
      bus(1'b0, 12'h020, 0);
      chk("unmapped", 0, rd);
      bus(1'b1, `REG_IRQ_MASK, 32'hf);
      bus(1'b1, `REG_CTRL, 32'h1);
      bus(1'b0, `REG_CTRL, 0);
      chk("ctrl", 1, rd);
    end
  endtask
  task testSwitch;
    for (n = 0; n < 2; n = n + 1) begin
      slowGate <= n[0];
      bus(1'b1, `REG_CTRL, 32'h1 | (n << 1));
      cycleStart <= 1'b1;
      for (i = 0; i < 30 && lowCmd !== 1'b1; i = i + 1) @(posedge mclk);
      chk("low on", 1, lowCmd);
      pwmTrip <= 1'b1;
      repeat (5) @(posedge mclk);
      chk("low off", 0, lowCmd);
      for (i = 0; i < 30 && highCmd !== 1'b1; i = i + 1) @(posedge mclk);
      chk("high on", 1, highCmd);
      zeroCurrentTrip <= n[0];
      repeat (5) @(posedge mclk);
      chk("high zero current", !n[0], highCmd);
      cycleStart <= 1'b0;
      pwmTrip <= 1'b0;
      zeroCurrentTrip <= 1'b0;
      repeat (12) @(posedge mclk);
    end
  endtask
  task testSkip;
    begin
      cycleStart <= 1'b1;
      for (i = 0; i < 30 && lowCmd !== 1'b1; i = i + 1) @(posedge mclk);
      peakLimitTrip <= 1'b1;
      repeat (5) @(posedge mclk);
      chk("low cut", 0, lowCmd);
      cycleStart <= 1'b0;
      repeat (12) @(posedge mclk);
      base = onCnt;
      repeat (3) tick(20);
      chk("peak skip", base, onCnt);
      chk("irq", 1, irq);
      peakLimitTrip <= 1'b0;
      pwmTrip <= 1'b1;
      base = onCnt;
      repeat (3) tick(20);
      chk("short skip", base, onCnt);
      pwmTrip <= 1'b0;
      bus(1'b1, `REG_IRQ_STAT, 32'hf);
      repeat (2) @(posedge mclk);
      chk("irq clear", 0, irq);
    end
  endtask
  task testBypassHot;
    begin
      overvoltageTrip <= 1'b1;
      supplyAboveTarget <= 1'b1;
      repeat (2) tick(20);
      for (i = 0; i < 3; i = i + 1) begin
        tick(0);
        chk("bypass", 1, highCmd);
        repeat (8) @(posedge mclk);
        chk("bypass", 1, highCmd);
      end
      overvoltageTrip <= 1'b0;
      overTempShutdown <= 1'b1;
      tick(20);
      chk("regulator off", 0, regEn);
      chk("gates off", 0, lowCmd | highCmd);
      bus(1'b0, `REG_STATUS, 0);
      chk("hot status", 1, rd[0]);
      supplyAboveTarget <= 1'b0;
      overTempShutdown <= 1'b0;
      tick(20);
      chk("regulator on", 1, regEn);
    end
  endtask
  task testLockout;
    begin
      enablePin <= 1'b0;
      base = onCnt;
      repeat (2) tick(20);
      chk("disabled", base, onCnt);
      enablePin <= 1'b1;
      driveSupplyOk <= 1'b0;
      repeat (2) tick(20);
      chk("drive lockout", base, onCnt);
      driveSupplyOk <= 1'b1;
      bootSupplyOk <= 1'b0;
      base = onCnt;
      for (n = 0; n < 90 && ssPull !== 1'b1; n = n + 1) tick(20);
      chk("replenish", `MAX_SETS * `MAX_REPLENISH * `REPLENISH_CYC, onCnt - base);
      chk("ticks to hiccup", 1, n >= 50 && n <= 68);
      chk("output_ok_flag pulled", 1, okPull);
      bootSupplyOk <= 1'b1;
      for (n = 0; n < 12 && ssPull === 1'b1; n = n + 1) tick(20);
      chk("hiccup length", 1, n >= 7 && n <= 9);
      chk("soft start", 0, ssPull);
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    testRegs;
    testSwitch;
    testSkip;
    testBypassHot;
    testLockout;
    stop_test;
  end
endmodule // boost_gate_drive_control_tb_top
